// File: hdl/fpg_regs.svh
`ifndef FPG_REGS_SVH
`define FPG_REGS_SVH
// Word addresses (Avalon word addressing)
`define FPG_ADDR_CONFIG   3'h0
`define FPG_ADDR_PHASE    3'h1
`define FPG_ADDR_CLKDIV   3'h2
`define FPG_ADDR_COMMAND  3'h3
`define FPG_ADDR_STATUS   3'h4
// Config fields
`define FPG_CFG_COUNT_LSB  0
`define FPG_CFG_COUNT_MSB  6
`define FPG_CFG_START_SEL  8
`define FPG_CFG_IDLE_SEL   9
`define FPG_CFG_RPT_LSB    24
`define FPG_CFG_RPT_MSB    26
`define FPG_CFG_DITHER_DIS 27
`define FPG_CFG_DRV_LSB    29
`define FPG_CFG_DRV_MSB    31
`define FPG_DRV_BOTH_BIT   2
`define FPG_DRV_UP_BIT     1
`define FPG_DRV_DOWN_BIT   0
// Clock divider fields
`define FPG_DIV_HS_LSB     0
`define FPG_DIV_HS_MSB     1
`define FPG_DIV_FIRE_LSB   4
`define FPG_DIV_FIRE_MSB   7
// Command and status
`define FPG_CMD_START_BIT  0
`define FPG_STS_BUSY_BIT   0
`define FPG_STS_ERR_BIT    1
// Reset values and phase mask count limit
`define FPG_CONFIG_RST     32'h0000_0000
`define FPG_PHASE_RST      16'h0000
`define FPG_HSDIV_RST      2'h0
`define FPG_FIREDIV_RST    4'h1
`define FPG_MAX_MASKED     7'h0f
// Reference accumulator step, in half clock cycles
`define FPG_HALF_STEP      8'h02
`define FPG_UNMAPPED_DATA  32'h0000_0000
`endif

// File: hdl/fpg_pkg.sv
`default_nettype none
package fpg_pkg;
  typedef enum logic [1:0] {
    FPG_IDLE = 2'b00,
    FPG_HIGH = 2'b01,
    FPG_LOW  = 2'b11
  } fpg_state_t;
endpackage
`default_nettype wire

// File: hdl/fpg_tick_if.sv
`default_nettype none
interface fpg_tick_if;
  logic [1:0] hs_div;
  logic [3:0] fire_div;
  logic       run;
  logic       dither_en;
  logic       tick;
  modport gen  (input hs_div, fire_div, run, dither_en, output tick);
  modport user (output hs_div, fire_div, run, dither_en, input tick);
endinterface
`default_nettype wire

// File: hdl/fpg_tick_gen.sv
`include "fpg_regs.svh"
`default_nettype none
module fpg_tick_gen (
  input  wire logic clk,
  input  wire logic reset_n,
  fpg_tick_if.gen   tif
);
  // ==========================================================
  // Reference tick: base clock doubled, over fire divider plus one and over 2^hs_div
  logic [7:0] len2;
  logic [7:0] acc_reg;
  logic [7:0] acc_sum;
  logic [7:0] lfsr_reg;
  logic       stall_reg;
  logic       ref_tick;

  // Period in half clock cycles: (div + 1) * 2^hs_div
  // Odd lengths alternate long and short phases, exact on average
  assign len2     = ({4'h0, tif.fire_div} + 8'h01) << tif.hs_div;
  assign acc_sum  = acc_reg + `FPG_HALF_STEP;
  assign ref_tick = tif.run && !stall_reg && (acc_sum >= len2);
  assign tif.tick = ref_tick;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg   <= 8'h00;
      lfsr_reg  <= 8'h01;
      stall_reg <= 1'b0;
    end else if (!tif.run) begin
      acc_reg   <= 8'h00;
      stall_reg <= 1'b0;
    end else if (stall_reg) begin
      stall_reg <= 1'b0;
    end else if (ref_tick) begin
      acc_reg   <= acc_sum - len2;
      lfsr_reg  <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      stall_reg <= tif.dither_en & lfsr_reg[0];
    end else begin
      acc_reg <= acc_sum;
    end
  end
endmodule
`default_nettype wire

// File: hdl/fpg_fire_pulse_gen.sv
`include "fpg_regs.svh"
`default_nettype none
module fpg_fire_pulse_gen #(
  parameter int COUNT_W = 7
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             fire_up_out,
  output logic             fire_up_oe,
  output logic             fire_down_out,
  output logic             fire_down_oe,
  output logic             tdc_start
);
  if (COUNT_W != 7) begin : g_bad_count_w
    $error("COUNT_W must be 7");
  end

  // ==========================================================
  // Registers and bus slave
  logic [31:0] config_reg;
  logic [15:0] phase_reg;
  logic [1:0]  hs_div_reg;
  logic [3:0]  fire_div_reg;
  logic        ack_reg;
  logic        div_err_reg;
  logic        busy_reg;
  logic        access;
  logic        wr_en;
  logic        start_cmd;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign access      = (avs_read || avs_write) && !ack_reg;
  // Write lands at the second edge, the one after the wait state, while waitrequest is low
  assign wr_en       = avs_write && ack_reg;
  assign start_cmd   = wr_en && (avs_address == `FPG_ADDR_COMMAND)
                       && avs_writedata[`FPG_CMD_START_BIT];
  assign status_word = {30'h0, div_err_reg, busy_reg};
  assign rd_mux = (avs_address == `FPG_ADDR_CONFIG) ? config_reg :
                  (avs_address == `FPG_ADDR_PHASE)  ? {16'h0, phase_reg} :
                  (avs_address == `FPG_ADDR_CLKDIV) ? {24'h0, fire_div_reg, 2'h0, hs_div_reg} :
                  (avs_address == `FPG_ADDR_STATUS) ? status_word : `FPG_UNMAPPED_DATA;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_reg      <= access;
      avs_readdata <= rd_mux;
    end
  end
  // One wait state: answer at the second edge
  assign avs_waitrequest = !ack_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg   <= `FPG_CONFIG_RST;
      phase_reg    <= `FPG_PHASE_RST;
      hs_div_reg   <= `FPG_HSDIV_RST;
      fire_div_reg <= `FPG_FIREDIV_RST;
    end else if (wr_en && avs_address == `FPG_ADDR_CONFIG) begin
      config_reg <= avs_writedata;
    end else if (wr_en && avs_address == `FPG_ADDR_PHASE) begin
      phase_reg <= avs_writedata[15:0];
    end else if (wr_en && avs_address == `FPG_ADDR_CLKDIV) begin
      hs_div_reg   <= avs_writedata[`FPG_DIV_HS_MSB:`FPG_DIV_HS_LSB];
      fire_div_reg <= avs_writedata[`FPG_DIV_FIRE_MSB:`FPG_DIV_FIRE_LSB];
    end
  end

  // ==========================================================
  // Field decode
  logic [6:0] cfg_count;
  logic [2:0] cfg_repeat;
  logic [2:0] cfg_drv;
  logic       cfg_idle_gnd;
  logic       cfg_start_sel;

  assign cfg_count     = config_reg[`FPG_CFG_COUNT_MSB:`FPG_CFG_COUNT_LSB];
  assign cfg_repeat    = config_reg[`FPG_CFG_RPT_MSB:`FPG_CFG_RPT_LSB];
  assign cfg_drv       = config_reg[`FPG_CFG_DRV_MSB:`FPG_CFG_DRV_LSB];
  assign cfg_idle_gnd  = config_reg[`FPG_CFG_IDLE_SEL];
  assign cfg_start_sel = config_reg[`FPG_CFG_START_SEL];

  // ==========================================================
  // Reference tick generator
  fpg_tick_if tif ();
  assign tif.hs_div    = hs_div_reg;
  assign tif.fire_div  = fire_div_reg;
  assign tif.run       = busy_reg;
  assign tif.dither_en = !config_reg[`FPG_CFG_DITHER_DIS];

  fpg_tick_gen u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // ==========================================================
  // Burst sequencer
  fpg_pkg::fpg_state_t state_reg;
  fpg_pkg::fpg_state_t state_next;
  logic [6:0] pulse_reg;
  logic [2:0] rpt_reg;
  logic       phase_bit;
  logic       last_pulse;
  logic       start_ok;
  logic       level;

  assign start_ok   = start_cmd && !busy_reg && (cfg_count != 7'h00)
                      && (fire_div_reg != 4'h0);
  assign phase_bit  = (cfg_count <= `FPG_MAX_MASKED)
                      && phase_reg[pulse_reg[3:0]];
  assign last_pulse = (pulse_reg == cfg_count - 7'h01);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fpg_pkg::FPG_IDLE: if (start_ok) state_next = fpg_pkg::FPG_HIGH;
      fpg_pkg::FPG_HIGH: if (tif.tick) state_next = fpg_pkg::FPG_LOW;
      fpg_pkg::FPG_LOW: begin
        if (tif.tick && last_pulse && rpt_reg == 3'h0) begin
          state_next = fpg_pkg::FPG_IDLE;
        end else if (tif.tick) begin
          state_next = fpg_pkg::FPG_HIGH;
        end
      end
      default: state_next = fpg_pkg::FPG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= fpg_pkg::FPG_IDLE;
      busy_reg  <= 1'b0;
      pulse_reg <= 7'h00;
      rpt_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (start_ok) begin
        busy_reg  <= 1'b1;
        pulse_reg <= 7'h00;
        rpt_reg   <= cfg_repeat;
      end else if (state_reg == fpg_pkg::FPG_LOW && tif.tick) begin
        if (!last_pulse) begin
          pulse_reg <= pulse_reg + 7'h01;
        end else if (rpt_reg != 3'h0) begin
          pulse_reg <= 7'h00;
          rpt_reg   <= rpt_reg - 3'h1;
        end else begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div_err_reg <= 1'b0;
    else if (start_cmd && fire_div_reg == 4'h0) div_err_reg <= 1'b1;
    else if (start_ok) div_err_reg <= 1'b0;
  end

  // ==========================================================
  // Output drivers
  logic up_en;
  logic dn_en;
  logic active;
  logic up_level;
  logic dn_level;

  assign active   = (state_reg == fpg_pkg::FPG_HIGH) || (state_reg == fpg_pkg::FPG_LOW);
  assign level    = (state_reg == fpg_pkg::FPG_HIGH) ^ phase_bit;
  assign up_en    = cfg_drv[`FPG_DRV_BOTH_BIT] || cfg_drv[`FPG_DRV_UP_BIT];
  assign dn_en    = cfg_drv[`FPG_DRV_BOTH_BIT] || cfg_drv[`FPG_DRV_DOWN_BIT];
  assign up_level = active && up_en && level;
  assign dn_level = active && dn_en && (cfg_drv[`FPG_DRV_BOTH_BIT] ? !level : level);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fire_up_out   <= 1'b0;
      fire_down_out <= 1'b0;
      fire_up_oe    <= 1'b0;
      fire_down_oe  <= 1'b0;
      tdc_start     <= 1'b0;
    end else begin
      fire_up_out   <= up_level;
      fire_down_out <= dn_level;
      fire_up_oe    <= (active && up_en) || cfg_idle_gnd;
      fire_down_oe  <= (active && dn_en) || cfg_idle_gnd;
      tdc_start     <= cfg_start_sel && start_ok;
    end
  end

  // ==========================================================
  // Checks
  a_zero_count_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (start_cmd && cfg_count == 7'h00) |=> !busy_reg)
    else $error("burst started with zero count");
  a_idle_ground_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (!active && cfg_idle_gnd) |=> (fire_up_oe && !fire_up_out))
    else $error("idle not driven to ground");
  a_start_routed: assert property (@(posedge clk) disable iff (!reset_n)
    (start_ok && cfg_start_sel) |=> tdc_start)
    else $error("start not routed");
  a_start_only_cmd: assert property (@(posedge clk) disable iff (!reset_n)
    ($rose(busy_reg)) |-> $past(start_cmd))
    else $error("burst without command");
  a_both_inverted: assert property (@(posedge clk) disable iff (!reset_n)
    (active && cfg_drv[`FPG_DRV_BOTH_BIT]) |=> (fire_down_out != fire_up_out))
    else $error("down not inverted");
  a_high_needs_tick: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == fpg_pkg::FPG_HIGH && !tif.tick) |=> state_reg == fpg_pkg::FPG_HIGH)
    else $error("high phase left early");
  a_done_to_idle: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(busy_reg) |-> state_reg == fpg_pkg::FPG_IDLE)
    else $error("not idle after burst");
  a_repeat_loaded: assert property (@(posedge clk) disable iff (!reset_n)
    start_ok |=> rpt_reg == $past(cfg_repeat))
    else $error("repeat not loaded");
  a_low_needs_tick: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == fpg_pkg::FPG_LOW && !tif.tick) |=> state_reg == fpg_pkg::FPG_LOW)
    else $error("low phase left early");
  a_idle_hiz_release: assert property (@(posedge clk) disable iff (!reset_n)
    (!active && !cfg_idle_gnd) |=> (!fire_up_oe && !fire_down_oe))
    else $error("idle driver not released");
  a_phase_first_half: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == fpg_pkg::FPG_HIGH && up_en && cfg_count <= `FPG_MAX_MASKED)
    |=> fire_up_out == !$past(phase_reg[pulse_reg[3:0]]))
    else $error("pulse phase wrong");
endmodule
`default_nettype wire

// File: verification/fpg_piezo_model.sv
`default_nettype none
// =============================
// Transducer load on both fire pins
module fpg_piezo_model (
  input  wire logic clk,
  input  wire logic up_out,
  input  wire logic up_oe,
  input  wire logic dn_out,
  input  wire logic dn_oe,
  output logic      up_pin,
  output logic      dn_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_last = 1'b0;
  logic dn_last = 1'b0;
  always @(posedge clk) begin
    if (up_oe) up_last <= up_out;
    if (dn_oe) dn_last <= dn_out;
  end
  // Released RC node floats, shown as inverse of last drive
  assign up_pin = up_oe ? up_out : ~up_last;
  assign dn_pin = dn_oe ? dn_out : ~dn_last;
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wait_rq, uo, uoe, dno, dnoe, tstart, up_pin, dn_pin, prev;
  int          err_total = 0;
  int          samples_checked = 0;
  int          rises, up_cyc, dn_cyc, starts, inv_bad;
  logic        mon = 1'b0;
  logic        q[$];
  always #4 clk = ~clk;
  fpg_fire_pulse_gen u_dut (.clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
    .fire_up_out(uo), .fire_up_oe(uoe), .fire_down_out(dno), .fire_down_oe(dnoe),
    .tdc_start(tstart));
  fpg_piezo_model u_piezo (.clk(clk), .up_out(uo), .up_oe(uoe), .dn_out(dno), .dn_oe(dnoe),
    .up_pin(up_pin), .dn_pin(dn_pin));
  // =============================
  // Burst monitor
  always @(negedge clk) begin
    if (mon) begin
      if (uoe === 1'b1) begin
        q.push_back(up_pin);
        if (up_pin === 1'b1 && prev !== 1'b1) rises++;
        up_cyc++;
      end
      prev = uoe & up_pin;
      if (dnoe === 1'b1) dn_cyc++;
      if (uoe === 1'b1 && dnoe === 1'b1 && dn_pin !== ~up_pin) inv_bad++;
      if (tstart === 1'b1) starts++;
    end
  end
  // =============================
  // Shared tasks
  task automatic conclude();
    $display("Checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    if (n >= 50) begin
      check("waitrequest", 32'h1, 32'h0);
      conclude();
    end
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic [31:0] cf(input logic [2:0] drv, input logic [2:0] rpt,
      input logic dis, input logic idle, input logic ssel, input logic [6:0] cnt);
    return {drv, 1'b0, dis, rpt, 14'h0, idle, ssel, 1'b0, cnt};
  endfunction
  task automatic burst(input logic [31:0] cfg, input logic [15:0] mask, input logic [3:0] fdiv,
                       input logic [1:0] hs);
    logic [31:0] r;
    int n;
    n = 0;
    bus(1'b1, 3'h0, cfg, r);
    bus(1'b1, 3'h1, {16'h0, mask}, r);
    bus(1'b1, 3'h2, {24'h0, fdiv, 2'h0, hs}, r);
    rises = 0; up_cyc = 0; dn_cyc = 0; starts = 0; inv_bad = 0; prev = 1'b0;
    q.delete();
    mon = 1'b1;
    bus(1'b1, 3'h3, 32'h1, r);
    do begin
      bus(1'b0, 3'h4, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      check("busy", 32'h1, 32'h0);
      conclude();
    end
    repeat (4) @(posedge clk);
    mon = 1'b0;
  endtask
  // =============================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    bus(1'b0, 3'h0, 32'h0, r); check("config_rst", r, 32'h0);
    bus(1'b0, 3'h2, 32'h0, r); check("clkdiv_rst", r, 32'h10);
    bus(1'b1, 3'h6, 32'hffff_ffff, r);
    bus(1'b0, 3'h6, 32'h0, r); check("unmapped", r, 32'h0);
    bus(1'b1, 3'h1, 32'h0000_7abc, r);
    bus(1'b0, 3'h1, 32'h0, r); check("phase_rw", r, 32'h0000_7abc);
  endtask
  task automatic t_phase();
    logic e;
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd7), 16'h0055, 4'h3, 2'h0);
    check("up_cycles", up_cyc, 28);
    check("down_cycles", dn_cyc, 0);
    check("start_off", starts, 0);
    for (int k = 0; k < 28; k++) begin
      e = ((16'h0055 >> (k / 4)) & 1) ? ((k / 2) % 2 == 1) : ((k / 2) % 2 == 0);
      check("phase_wave", q[k], e);
    end
  endtask
  task automatic t_counts();
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd0), 16'h0, 4'h1, 2'h0);
    check("zero_rises", rises, 0);
    check("zero_cycles", up_cyc, 0);
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd127), 16'h0, 4'h1, 2'h0);
    check("max_rises", rises, 127);
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd16), 16'h7fff, 4'h1, 2'h0);
    check("long_first", q[0], 1);
    // Repeats without simulation section
    for (int r = 0; r < 8; r++) begin
      burst(cf(3'b010, r[2:0], 1'b1, 1'b0, 1'b0, 7'd2), 16'h0, 4'h1, 2'h0);
      check("repeat_rises", rises, 2 * (1 + r));
    end
  endtask
  task automatic t_drive();
    burst(cf(3'b100, 3'h0, 1'b1, 1'b0, 1'b1, 7'd3), 16'h0005, 4'h3, 2'h0);
    check("both_inverse", inv_bad, 0);
    check("both_down", dn_cyc, 12);
    check("start_on", starts, 1);
    burst(cf(3'b001, 3'h0, 1'b1, 1'b0, 1'b0, 7'd3), 16'h0, 4'h3, 2'h0);
    check("down_only_up", up_cyc, 0);
    check("down_only_dn", dn_cyc, 12);
  endtask
  task automatic t_idle();
    burst(cf(3'b100, 3'h0, 1'b1, 1'b1, 1'b0, 7'd2), 16'h0, 4'h1, 2'h0);
    @(negedge clk);
    check("gnd_idle", {uoe, dnoe, uo, dno}, 4'b1100);
    burst(cf(3'b100, 3'h0, 1'b1, 1'b0, 1'b0, 7'd2), 16'h0, 4'h1, 2'h0);
    @(negedge clk);
    check("hiz_idle", {uoe, dnoe}, 2'b00);
  endtask
  task automatic t_clock();
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd2), 16'h0, 4'h3, 2'h1);
    check("hs_div_cycles", up_cyc, 16);
    // Divider 2 at base rate: 1.5 cycles per reference period
    burst(cf(3'b010, 3'h0, 1'b1, 1'b0, 1'b0, 7'd2), 16'h0, 4'h2, 2'h0);
    check("frac_cycles", up_cyc, 6);
    burst(cf(3'b010, 3'h0, 1'b0, 1'b0, 1'b0, 7'd2), 16'h0, 4'h3, 2'h1);
    check("dither_rises", rises, 2);
    check("dither_long", up_cyc >= 16, 1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_phase();
    t_counts();
    t_drive();
    t_idle();
    t_clock();
    conclude();
  end
endmodule
`default_nettype wire
